// *** rtl/pfdp_pkg.sv ***
// pfdp_pkg: constants, types and group map for the peripheral frame decoder
// assumes word addresses of 22 bits, 32-bit data words, one system clock
// Overview of operation
// - route each mapped access to one of four frames
// - frame 0 served straight from cpu bus
// - frame 1 over 32-bit peripheral bus
// - frame 2 over 16-bit peripheral bus
// - frame 3 over 32-bit bus, dma reachable
// - frame 0 accepts 16 and 32-bit accesses
// - protected group writes need write window open
// - write-disable instruction closes the write window
// - flash writes also need security module permission
// - 0x0880-0x09ff device emulation group, protected
// - 0x0a80-0x0adf flash control group, protected
// - 0x0ae0-0x0aef security module group, protected
// - 0x0b00-0x0b0f converter mirror, read-only, cpu reads wait one cycle, dma none
// - 0x0b20-0x0b3f external memory interface, protected
// - 0x0c00-0x0c3f cpu timers, unprotected
// - 0x0ce0-0x0cff interrupt expansion, unprotected
// - 0x0d00-0x0dff interrupt vector table, protected
// - 0x1000-0x11ff dma registers, protected
// - protected map bit moves pwm frame 1/3
package pfdp_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 32;

	typedef enum logic [3:0] {
		PFDP_G_NONE = 4'h0,
		PFDP_G_EMU = 4'h1,
		PFDP_G_FLASH = 4'h2,
		PFDP_G_SEC = 4'h3,
		PFDP_G_ADCM = 4'h4,
		PFDP_G_XMEM = 4'h5,
		PFDP_G_TIMER = 4'h6,
		PFDP_G_INTX = 4'h7,
		PFDP_G_VECT = 4'h8,
		PFDP_G_DMA = 4'h9
	} pfdp_group_t;

	typedef enum logic [2:0] {
		PFDP_F_NONE = 3'h0,
		PFDP_F0 = 3'h1,
		PFDP_F1 = 3'h2,
		PFDP_F2 = 3'h3,
		PFDP_F3 = 3'h4
	} pfdp_frame_t;

	localparam logic [ADDR_W-1:0] EMU_LO = 22'h000880;
	localparam logic [ADDR_W-1:0] EMU_HI = 22'h0009ff;
	localparam logic [ADDR_W-1:0] FLASH_LO = 22'h000a80;
	localparam logic [ADDR_W-1:0] FLASH_HI = 22'h000adf;
	localparam logic [ADDR_W-1:0] SEC_LO = 22'h000ae0;
	localparam logic [ADDR_W-1:0] SEC_HI = 22'h000aef;
	localparam logic [ADDR_W-1:0] ADCM_LO = 22'h000b00;
	localparam logic [ADDR_W-1:0] ADCM_HI = 22'h000b0f;
	localparam logic [ADDR_W-1:0] XMEM_LO = 22'h000b20;
	localparam logic [ADDR_W-1:0] XMEM_HI = 22'h000b3f;
	localparam logic [ADDR_W-1:0] TIMER_LO = 22'h000c00;
	localparam logic [ADDR_W-1:0] TIMER_HI = 22'h000c3f;
	localparam logic [ADDR_W-1:0] INTX_LO = 22'h000ce0;
	localparam logic [ADDR_W-1:0] INTX_HI = 22'h000cff;
	localparam logic [ADDR_W-1:0] VECT_LO = 22'h000d00;
	localparam logic [ADDR_W-1:0] VECT_HI = 22'h000dff;
	localparam logic [ADDR_W-1:0] DMA_LO = 22'h001000;
	localparam logic [ADDR_W-1:0] DMA_HI = 22'h0011ff;
	// frame windows for 1, 2, 3
	localparam logic [ADDR_W-1:0] F1_LO = 22'h006000;
	localparam logic [ADDR_W-1:0] F1_HI = 22'h006fff;
	localparam logic [ADDR_W-1:0] F2_LO = 22'h007000;
	localparam logic [ADDR_W-1:0] F2_HI = 22'h007fff;
	localparam logic [ADDR_W-1:0] F3_LO = 22'h005000;
	localparam logic [ADDR_W-1:0] F3_HI = 22'h005fff;
	// pwm groups in frame 1 and frame 3 views
	localparam logic [ADDR_W-1:0] PWM1_LO = 22'h006800;
	localparam logic [ADDR_W-1:0] PWM1_HI = 22'h00697f;
	localparam logic [ADDR_W-1:0] PWM3_LO = 22'h005800;
	localparam logic [ADDR_W-1:0] PWM3_HI = 22'h00597f;
	// frame map config word and its pwm select bit
	localparam logic [ADDR_W-1:0] FRAME_MAP_CONFIG_ADDR = 22'h00702e;
	localparam int PWM_FRAME_MAP_SELECT_BIT = 0;
	localparam logic PWM_MAP_RST = 1'b0;
	localparam logic WIN_RST = 1'b0;
	// converter mirror waits
	localparam int ADCM_WAIT_CPU = 1;
	localparam int ADCM_WAIT_DMA = 0;

	typedef struct packed {
		logic valid;
		logic write;
		logic is_dma;
		logic wide;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pfdp_req_t;

	typedef struct packed {
		pfdp_frame_t frame;
		pfdp_group_t group;
		logic prot;
		logic wr_en;
		logic wide;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pfdp_fwd_t;

	function automatic logic pfdp_in(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction
endpackage

// *** rtl/pfdp_f0_decode.sv ***
// pfdp_f0_decode: frame 0 group decode, combinational
// assumes a word address from the cpu memory bus
`timescale 1ns/100ps
`default_nettype none
module pfdp_f0_decode
	import pfdp_pkg::*;
(
	// address in
	input wire logic [ADDR_W-1:0] addr,
	// decode out
	output pfdp_group_t group,
	output logic prot
);
	wire logic h_emu = pfdp_in(addr, EMU_LO, EMU_HI);
	wire logic h_flash = pfdp_in(addr, FLASH_LO, FLASH_HI);
	wire logic h_sec = pfdp_in(addr, SEC_LO, SEC_HI);
	wire logic h_adcm = pfdp_in(addr, ADCM_LO, ADCM_HI);
	wire logic h_xmem = pfdp_in(addr, XMEM_LO, XMEM_HI);
	wire logic h_timer = pfdp_in(addr, TIMER_LO, TIMER_HI);
	wire logic h_intx = pfdp_in(addr, INTX_LO, INTX_HI);
	wire logic h_vect = pfdp_in(addr, VECT_LO, VECT_HI);
	wire logic h_dma = pfdp_in(addr, DMA_LO, DMA_HI);

	assign group = h_emu ? PFDP_G_EMU :
		h_flash ? PFDP_G_FLASH :
		h_sec ? PFDP_G_SEC :
		h_adcm ? PFDP_G_ADCM :
		h_xmem ? PFDP_G_XMEM :
		h_timer ? PFDP_G_TIMER :
		h_intx ? PFDP_G_INTX :
		h_vect ? PFDP_G_VECT :
		h_dma ? PFDP_G_DMA : PFDP_G_NONE;
	// timers, interrupt expansion and mirror stay open
	assign prot = h_emu | h_flash | h_sec | h_xmem | h_vect | h_dma;
endmodule
`default_nettype wire

// *** rtl/pfdp_wr_window.sv ***
// pfdp_wr_window: protected-write window flag
// assumes one-cycle instruction pulses from the cpu core
`timescale 1ns/100ps
`default_nettype none
module pfdp_wr_window
	import pfdp_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// instruction pulses
	input wire logic write_allow_instruction,
	input wire logic write_disable_instruction,
	// window state
	output logic win_open
);
	logic win_r;
	logic win_nxt;
	// disable wins if both arrive: safer to stay shut
	assign win_nxt = write_disable_instruction ? 1'b0 :
		write_allow_instruction ? 1'b1 : win_r;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			win_r <= WIN_RST;
		end else begin
			win_r <= win_nxt;
		end
	end
	assign win_open = win_r;

	a_win_closes: assert property (@(posedge ref_clk) disable iff (!rst_b)
		write_disable_instruction |=> !win_open) else $error("window stayed open");
	a_win_opens: assert property (@(posedge ref_clk) disable iff (!rst_b)
		write_allow_instruction && !write_disable_instruction |=> win_open)
		else $error("window did not open");
endmodule
`default_nettype wire

// *** rtl/pfdp_top.sv ***
// pfdp_top: sorts cpu and dma accesses into four frames, gates protected writes
// assumes one request a cycle, peripherals answer on their own buses
`timescale 1ns/100ps
`default_nettype none
module pfdp_top
	import pfdp_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// cpu core
	input wire pfdp_req_t cpu_req,
	input wire logic write_allow_instruction,
	input wire logic write_disable_instruction,
	output logic cpu_ready,
	output logic [DATA_W-1:0] cpu_rdata,
	// dma controller
	input wire pfdp_req_t dma_req,
	output logic dma_ready,
	output logic [DATA_W-1:0] dma_rdata,
	// security module permission level
	input wire logic code_security_module_open,
	// frame 0 cpu memory bus
	output pfdp_fwd_t f0_bus,
	input wire logic [DATA_W-1:0] f0_rdata,
	// converter mirror read data
	input wire logic [DATA_W-1:0] adcm_rdata,
	// frame 1 32-bit bus
	output pfdp_fwd_t f1_bus,
	input wire logic [31:0] f1_rdata,
	// frame 2 16-bit bus
	output pfdp_fwd_t f2_bus,
	input wire logic [15:0] f2_rdata,
	// frame 3 32-bit dma-capable bus
	output pfdp_fwd_t f3_bus,
	input wire logic [31:0] f3_rdata,
	// map state
	output logic pwm_frame_map_select
);
	logic win_open;
	logic pwm_map_r;
	logic pwm_map_nxt;
	logic adcm_wait_r;
	logic adcm_wait_nxt;
	pfdp_group_t cpu_grp;
	logic cpu_prot;
	pfdp_group_t dma_grp;
	logic dma_prot;

	pfdp_wr_window u_win (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.write_allow_instruction(write_allow_instruction),
		.write_disable_instruction(write_disable_instruction),
		.win_open(win_open)
	);

	pfdp_f0_decode u_cpu_dec (
		.addr(cpu_req.addr),
		.group(cpu_grp),
		.prot(cpu_prot)
	);

	pfdp_f0_decode u_dma_dec (
		.addr(dma_req.addr),
		.group(dma_grp),
		.prot(dma_prot)
	);

	// cpu frame select
	wire logic [ADDR_W-1:0] ca = cpu_req.addr;
	wire logic c_pwm1 = pfdp_in(ca, PWM1_LO, PWM1_HI);
	wire logic c_pwm3 = pfdp_in(ca, PWM3_LO, PWM3_HI);
	// pwm windows answer only in the frame the map bit selects
	wire logic c_f0 = cpu_grp != PFDP_G_NONE;
	wire logic c_f1 = pfdp_in(ca, F1_LO, F1_HI) && !(c_pwm1 && pwm_map_r);
	wire logic c_f2 = pfdp_in(ca, F2_LO, F2_HI);
	wire logic c_f3 = pfdp_in(ca, F3_LO, F3_HI) && !(c_pwm3 && !pwm_map_r);
	wire pfdp_frame_t c_frame = c_f0 ? PFDP_F0 : c_f1 ? PFDP_F1 :
		c_f2 ? PFDP_F2 : c_f3 ? PFDP_F3 : PFDP_F_NONE;

	// dma sees frame 0 and frame 3 only
	wire logic [ADDR_W-1:0] da = dma_req.addr;
	wire logic d_pwm3 = pfdp_in(da, PWM3_LO, PWM3_HI);
	wire logic d_f0 = dma_grp != PFDP_G_NONE;
	wire logic d_f3 = pfdp_in(da, F3_LO, F3_HI) && !(d_pwm3 && !pwm_map_r);
	wire logic dma_go = dma_req.valid && (d_f0 || d_f3);

	// map config word lives in frame 2 and is itself protected
	wire logic c_map_hit = ca == FRAME_MAP_CONFIG_ADDR;
	wire logic c_prot = c_f0 ? cpu_prot : c_map_hit;
	wire logic d_prot = d_f0 && dma_prot;

	// write gating; suppressed writes still complete
	wire logic c_flash = c_f0 && cpu_grp == PFDP_G_FLASH;
	wire logic c_ro = c_f0 && cpu_grp == PFDP_G_ADCM;
	wire logic c_sec_ok = !c_flash || code_security_module_open;
	wire logic c_wr_ok = cpu_req.write && !c_ro && c_sec_ok
		&& (!c_prot || win_open);
	// the window belongs to the cpu; dma never opens it
	wire logic d_flash = d_f0 && dma_grp == PFDP_G_FLASH;
	wire logic d_ro = d_f0 && dma_grp == PFDP_G_ADCM;
	wire logic d_wr_ok = dma_req.write && !d_ro && !d_flash && (!d_prot || win_open);

	// dma owns frame 3 if both target it; cpu retries
	wire logic clash = cpu_req.valid && c_f3 && dma_go && d_f3;
	wire logic cpu_go = cpu_req.valid && c_frame != PFDP_F_NONE && !clash;
	wire logic dma_f0_win = dma_go && d_f0 && !(cpu_go && c_f0);
	wire logic dma_f3_win = dma_go && d_f3;

	// converter mirror: cpu takes one wait, dma none
	wire logic c_adcm_rd = cpu_req.valid && !cpu_req.write && c_ro;
	assign adcm_wait_nxt = c_adcm_rd && !adcm_wait_r;

	// map bit write
	wire logic map_wr = cpu_go && c_f2 && c_map_hit && c_wr_ok;
	assign pwm_map_nxt = map_wr ? cpu_req.wdata[PWM_FRAME_MAP_SELECT_BIT] : pwm_map_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwm_map_r <= PWM_MAP_RST;
			adcm_wait_r <= 1'b0;
		end else begin
			pwm_map_r <= pwm_map_nxt;
			adcm_wait_r <= adcm_wait_nxt;
		end
	end
	assign pwm_frame_map_select = pwm_map_r;

	// forwarding; wide bit passed through on frame 0
	function automatic pfdp_fwd_t fwd(input logic go, input pfdp_frame_t fr,
		input pfdp_group_t g, input logic p, input logic wok, input pfdp_req_t r);
		pfdp_fwd_t f;
		f = '0;
		if (go) begin
			f.frame = fr;
			f.group = g;
			f.prot = p;
			f.wr_en = wok;
			f.wide = r.wide;
			f.addr = r.addr;
			f.wdata = r.wdata;
		end
		return f;
	endfunction

	wire logic c0 = cpu_go && c_f0 && !(dma_f0_win);
	assign f0_bus = dma_f0_win ? fwd(1'b1, PFDP_F0, dma_grp, d_prot, d_wr_ok, dma_req)
		: fwd(c0, PFDP_F0, cpu_grp, c_prot, c_wr_ok, cpu_req);
	assign f1_bus = fwd(cpu_go && c_f1, PFDP_F1, PFDP_G_NONE, 1'b0, c_wr_ok, cpu_req);
	// frame 2 is 16 bits: wide requests go out narrow
	pfdp_req_t c_narrow;
	always_comb begin
		c_narrow = cpu_req;
		c_narrow.wide = 1'b0;
		c_narrow.wdata = {16'h0000, cpu_req.wdata[15:0]};
	end
	assign f2_bus = fwd(cpu_go && c_f2, PFDP_F2, PFDP_G_NONE, c_map_hit, c_wr_ok,
		c_narrow);
	assign f3_bus = dma_f3_win ? fwd(1'b1, PFDP_F3, PFDP_G_NONE, 1'b0, d_wr_ok, dma_req)
		: fwd(cpu_go && c_f3, PFDP_F3, PFDP_G_NONE, 1'b0, c_wr_ok, cpu_req);

	// answers: cpu waits behind dma on frame 3 clash; dma waits behind cpu on frame 0
	wire logic cpu_lost = (c_f0 && dma_f0_win) || clash;
	assign cpu_ready = !cpu_req.valid || c_frame == PFDP_F_NONE ||
		(!cpu_lost && (!c_adcm_rd || adcm_wait_r));
	assign dma_ready = !dma_req.valid || !dma_go || dma_f3_win || dma_f0_win;

	wire logic [DATA_W-1:0] c_rd = c_ro ? adcm_rdata : c_f0 ? f0_rdata :
		c_f1 ? f1_rdata : c_f2 ? {16'h0000, f2_rdata} : c_f3 ? f3_rdata : '0;
	wire logic [DATA_W-1:0] d_rd = (d_f0 && dma_grp == PFDP_G_ADCM) ? adcm_rdata :
		d_f0 ? f0_rdata : d_f3 ? f3_rdata : '0;
	wire logic [DATA_W-1:0] c_rd_w = cpu_req.wide ? c_rd : {16'h0000, c_rd[15:0]};
	wire logic [DATA_W-1:0] d_rd_w = dma_req.wide ? d_rd : {16'h0000, d_rd[15:0]};
	logic [DATA_W-1:0] cpu_rdata_r;
	logic [DATA_W-1:0] dma_rdata_r;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_rdata_r <= '0;
			dma_rdata_r <= '0;
		end else begin
			cpu_rdata_r <= c_rd_w;
			dma_rdata_r <= d_rd_w;
		end
	end
	assign cpu_rdata = cpu_rdata_r;
	assign dma_rdata = dma_rdata_r;

	a_prot_blocked: assert property (@(posedge ref_clk) disable iff (!rst_b)
		f0_bus.frame == PFDP_F0 && f0_bus.prot && !win_open |-> !f0_bus.wr_en)
		else $error("protected write passed");
	a_flash_needs_sec: assert property (@(posedge ref_clk) disable iff (!rst_b)
		c0 && c_flash && !code_security_module_open |-> !f0_bus.wr_en)
		else $error("flash write without security");
	a_mirror_ro: assert property (@(posedge ref_clk) disable iff (!rst_b)
		f0_bus.group == PFDP_G_ADCM |-> !f0_bus.wr_en) else $error("mirror written");
	a_mirror_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
		c_adcm_rd && !cpu_lost && !$past(c_adcm_rd) |-> !cpu_ready ##1 (cpu_ready || !c_adcm_rd))
		else $error("mirror wait wrong");
	a_timer_open: assert property (@(posedge ref_clk) disable iff (!rst_b)
		c0 && cpu_req.write && cpu_grp == PFDP_G_TIMER |-> f0_bus.wr_en)
		else $error("timer write blocked");
	a_map_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!win_open |=> $stable(pwm_frame_map_select)) else $error("map bit changed");
	a_one_frame: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$onehot0({f1_bus.frame != PFDP_F_NONE, f2_bus.frame != PFDP_F_NONE}))
		else $error("two frames driven");
	a_dma_owns_f3: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clash |-> !cpu_ready && f3_bus.addr == dma_req.addr) else $error("dma lost frame 3");
endmodule
`default_nettype wire

// *** bench/pfdp_periph_model.sv ***
// pfdp_periph_model: peripheral side of the four frame buses, read data only
// assumes the decoder's forwarded buses are all zero when idle
`timescale 1ns/100ps
`default_nettype none
module pfdp_periph_model
	import pfdp_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// forwarded buses
	input wire pfdp_fwd_t f0_bus,
	input wire pfdp_fwd_t f1_bus,
	input wire pfdp_fwd_t f2_bus,
	input wire pfdp_fwd_t f3_bus,
	// read data back
	output logic [31:0] f0_rdata,
	output logic [31:0] adcm_rdata,
	output logic [31:0] f1_rdata,
	output logic [15:0] f2_rdata,
	output logic [31:0] f3_rdata
);
	// unselected buses show changing junk, so a stale value never matches
	logic [31:0] noise_r = 32'h5a5a_a5a5;
	wire logic adcm_sel = (f0_bus.frame == PFDP_F0) && (f0_bus.group == PFDP_G_ADCM);
	always @(posedge ref_clk) begin
		noise_r <= ~noise_r + 32'h0000_1357;
	end
	assign f0_rdata = (f0_bus.frame == PFDP_F0) ? (32'h0f00_0000 | {10'h0, f0_bus.addr}) : noise_r;
	assign adcm_rdata = adcm_sel ? (32'had00_0000 | {10'h0, f0_bus.addr}) : ~noise_r;
	assign f1_rdata = (f1_bus.frame == PFDP_F1) ? (32'h1100_0000 | {10'h0, f1_bus.addr}) : noise_r;
	assign f2_rdata = (f2_bus.frame == PFDP_F2) ? {4'ha, f2_bus.addr[11:0]} : noise_r[15:0];
	assign f3_rdata = (f3_bus.frame == PFDP_F3) ? (32'h3300_0000 | {10'h0, f3_bus.addr}) : noise_r;
endmodule
`default_nettype wire

// *** bench/pfdp_top_tb_top.sv ***
// pfdp_top_tb_top: directed bench for the frame decoder and write gate
// assumes the peripheral model answers reads on the same cycle
`timescale 1ns/100ps
`default_nettype none
module pfdp_top_tb_top;
	import pfdp_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	pfdp_req_t cpu_req = '0;
	pfdp_req_t dma_req = '0;
	logic allow = 1'b0;
	logic dis = 1'b0;
	logic code_security_module = 1'b1;
	logic cpu_ready, dma_ready, map_sel;
	logic [31:0] cpu_rdata, dma_rdata, f0_rd, adcm_rd, f1_rd, f3_rd;
	logic [15:0] f2_rd;
	pfdp_fwd_t f0_bus, f1_bus, f2_bus, f3_bus, b0, b1, b2, b3;
	logic [31:0] rd;
	int lat;
	int fails = 0;
	int checks = 0;
	always #25 ref_clk = ~ref_clk;
	pfdp_top u_pfdp_top (.ref_clk(ref_clk), .rst_b(rst_b), .cpu_req(cpu_req),
		.write_allow_instruction(allow), .write_disable_instruction(dis),
		.cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .dma_req(dma_req),
		.dma_ready(dma_ready), .dma_rdata(dma_rdata), .code_security_module_open(code_security_module),
		.f0_bus(f0_bus), .f0_rdata(f0_rd), .adcm_rdata(adcm_rd), .f1_bus(f1_bus),
		.f1_rdata(f1_rd), .f2_bus(f2_bus), .f2_rdata(f2_rd), .f3_bus(f3_bus),
		.f3_rdata(f3_rd), .pwm_frame_map_select(map_sel));
	pfdp_periph_model u_pfdp_periph_model (.ref_clk(ref_clk), .f0_bus(f0_bus),
		.f1_bus(f1_bus), .f2_bus(f2_bus), .f3_bus(f3_bus), .f0_rdata(f0_rd),
		.adcm_rdata(adcm_rd), .f1_rdata(f1_rd), .f2_rdata(f2_rd), .f3_rdata(f3_rd));
	task finish_test;
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one request, held until ready, then read data one edge later
	task go(input logic dm, input logic w, input logic wd, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		pfdp_req_t r;
		r = '{valid:1'b1, write:w, is_dma:dm, wide:wd, addr:a, wdata:d};
		@(negedge ref_clk);
		if (dm) dma_req = r; else cpu_req = r;
		lat = 0;
		#1;
		while ((dm ? dma_ready : cpu_ready) !== 1'b1 && lat < 8) begin
			@(negedge ref_clk);
			#1;
			lat++;
		end
		if (lat == 8) begin
			fails++;
			finish_test;
		end
		b0 = f0_bus;
		b1 = f1_bus;
		b2 = f2_bus;
		b3 = f3_bus;
		@(negedge ref_clk);
		cpu_req = '0;
		dma_req = '0;
		#1;
		rd = dm ? dma_rdata : cpu_rdata;
	endtask
	task pulse(input logic open);
		@(negedge ref_clk);
		if (open) allow = 1'b1; else dis = 1'b1;
		@(negedge ref_clk);
		allow = 1'b0;
		dis = 1'b0;
	endtask
	task s_protect;
		logic [ADDR_W-1:0] pa [6];
		logic [ADDR_W-1:0] ua [4];
		pa = '{EMU_HI, FLASH_LO, SEC_HI, XMEM_LO, VECT_HI, DMA_HI};
		ua = '{TIMER_LO, TIMER_HI, INTX_LO, INTX_HI};
		for (int i = 0; i < 6; i++) begin
			go(1'b0, 1'b1, 1'b1, pa[i], 32'h0000_1234);
			chk({b0.prot, b0.wr_en, 29'h0, cpu_ready}, 32'h8000_0001);
		end
		pulse(1'b1);
		for (int i = 0; i < 6; i++) begin
			go(1'b0, 1'b1, 1'b1, pa[i], 32'h0000_1234);
			chk({b0.prot, b0.wr_en}, 2'b11);
		end
		@(negedge ref_clk) code_security_module = 1'b0;
		go(1'b0, 1'b1, 1'b1, FLASH_HI, 32'h0000_0055);
		chk(b0.wr_en, 1'b0);
		@(negedge ref_clk) code_security_module = 1'b1;
		pulse(1'b0);
		go(1'b0, 1'b1, 1'b1, DMA_LO, 32'h0000_0077);
		chk(b0.wr_en, 1'b0);
		for (int i = 0; i < 4; i++) begin
			go(1'b0, 1'b1, 1'b1, ua[i], 32'h0000_00aa);
			chk({b0.prot, b0.wr_en}, 2'b01);
		end
		go(1'b0, 1'b0, 1'b1, 22'h000a00, 32'h0);
		chk(b0.frame, PFDP_F_NONE);
		chk(rd, 32'h0);
	endtask
	task s_mirror;
		go(1'b0, 1'b0, 1'b1, ADCM_LO, 32'h0);
		chk(lat, ADCM_WAIT_CPU);
		chk(rd, 32'had00_0b00);
		go(1'b1, 1'b0, 1'b1, ADCM_HI, 32'h0);
		chk(lat, ADCM_WAIT_DMA);
		chk(rd, 32'had00_0b0f);
		pulse(1'b1);
		go(1'b0, 1'b1, 1'b1, ADCM_LO, 32'h0000_ffff);
		chk(b0.wr_en, 1'b0);
		pulse(1'b0);
	endtask
	task s_frames;
		go(1'b0, 1'b0, 1'b1, F1_LO, 32'h0);
		chk(b1.frame, PFDP_F1);
		chk(rd, 32'h1100_6000);
		go(1'b0, 1'b0, 1'b1, F2_HI, 32'h0);
		chk({b2.frame, b2.wide}, {PFDP_F2, 1'b0});
		chk(rd, 32'h0000_afff);
		go(1'b0, 1'b0, 1'b1, F3_LO, 32'h0);
		chk(b3.frame, PFDP_F3);
		chk(rd, 32'h3300_5000);
		go(1'b1, 1'b0, 1'b1, F3_HI, 32'h0);
		chk(b3.frame, PFDP_F3);
		chk(rd, 32'h3300_5fff);
		go(1'b0, 1'b0, 1'b0, TIMER_LO, 32'h0);
		chk(b0.frame, PFDP_F0);
		chk(rd, 32'h0000_0c00);
		go(1'b0, 1'b0, 1'b1, TIMER_HI, 32'h0);
		chk(rd, 32'h0f00_0c3f);
	endtask
	task s_map;
		go(1'b0, 1'b1, 1'b1, FRAME_MAP_CONFIG_ADDR, 32'h0000_0001);
		chk(map_sel, 1'b0);
		go(1'b0, 1'b0, 1'b1, PWM1_LO, 32'h0);
		chk(b1.frame, PFDP_F1);
		go(1'b1, 1'b0, 1'b1, PWM3_LO, 32'h0);
		chk({b3.frame, lat}, {PFDP_F_NONE, 32'h0});
		chk(rd, 32'h0);
		pulse(1'b1);
		go(1'b0, 1'b1, 1'b1, FRAME_MAP_CONFIG_ADDR, 32'h5555_0001);
		chk(b2.wdata, 32'h0000_0001);
		chk(map_sel, 1'b1);
		go(1'b1, 1'b0, 1'b1, PWM3_HI, 32'h0);
		chk(b3.frame, PFDP_F3);
		chk(rd, 32'h3300_597f);
		go(1'b0, 1'b0, 1'b1, PWM1_LO, 32'h0);
		chk(b1.frame, PFDP_F_NONE);
		chk(rd, 32'h0);
		pulse(1'b0);
	endtask
	// both masters on frame 3 in one cycle: dma goes first, cpu one cycle later
	task s_clash;
		@(negedge ref_clk);
		cpu_req = '{valid:1'b1, write:1'b0, is_dma:1'b0, wide:1'b1, addr:F3_LO, wdata:32'h0};
		dma_req = '{valid:1'b1, write:1'b0, is_dma:1'b1, wide:1'b1, addr:F3_HI, wdata:32'h0};
		#1;
		chk({cpu_ready, dma_ready}, 2'b01);
		chk(f3_bus.addr, F3_HI);
		@(negedge ref_clk);
		dma_req = '0;
		#1;
		chk(dma_rdata, 32'h3300_5fff);
		chk({cpu_ready, f3_bus.addr}, {1'b1, F3_LO});
		@(negedge ref_clk);
		cpu_req = '0;
		#1;
		chk(cpu_rdata, 32'h3300_5000);
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_b = 1'b1;
		s_protect;
		s_mirror;
		s_frames;
		s_map;
		s_clash;
		finish_test;
	end
endmodule
`default_nettype wire
